// ===== logic/ctad_map.vh
// Field positions, encodings and register offsets for the transaction attribute decoder
`ifndef CTAD_MAP_VH
`define CTAD_MAP_VH

// Error cause word layout
`define CTAD_ETYPE_HI        63
`define CTAD_ETYPE_LO        58
`define CTAD_INFO_W          58
`define CTAD_CMD_HI          17
`define CTAD_CMD_LO          14
`define CTAD_GRP_HI          13
`define CTAD_GRP_LO          11
`define CTAD_ATTR_HI         10
`define CTAD_ATTR_LO         8
`define CTAD_TYPE_HI         4
`define CTAD_TYPE_LO         1

// Command groups
`define CTAD_GRP_PLAIN       3'h0
`define CTAD_GRP_REGSYNC     3'h1
`define CTAD_GRP_GLOBAL      3'h2
`define CTAD_GRP_RSVD        3'h3
`define CTAD_GRP_L1I         3'h4
`define CTAD_GRP_L1D         3'h5
`define CTAD_GRP_L3          3'h6
`define CTAD_GRP_L2          3'h7

// Coherency attribute codes
`define CTAD_ATTR_UNCACHED   3'h2
`define CTAD_ATTR_CRS        3'h5
`define CTAD_ATTR_UNC_ACCEL  3'h7

// Decoded attribute classes
`define CTAD_CLS_CRS         2'h0
`define CTAD_CLS_UNCACHED    2'h1
`define CTAD_CLS_UNC_ACCEL   2'h2

// Transaction type codes
`define CTAD_TT_REQ_NODATA   4'h0
`define CTAD_TT_REQ_DATA     4'h2

// Transaction type classes
`define CTAD_TC_REQ_NODATA   3'h0
`define CTAD_TC_REQ_DATA     3'h1
`define CTAD_TC_INTERVENE    3'h2
`define CTAD_TC_RESPONSE     3'h3
`define CTAD_TC_RSVD         3'h4

// Operation codes: {class,command} flattened, reserved marks illegal
`define CTAD_OP_W            6
`define CTAD_OP_RSVD         6'h3f

// Register map (byte offsets)
`define CTAD_REG_CAUSE_LO    4'h0
`define CTAD_REG_CAUSE_HI    4'h4
`define CTAD_REG_DECODE      4'h8
`define CTAD_REG_ETYPE       4'hc

`endif

// ===== logic/ctad_decode.v
// Transaction attribute decoder for the error detail word
`timescale 1ns/1ps
// Overview of operation
// - Group 0 plain, 1 register/sync, 2 global
// - Groups 4..7 target L1I, L1D, L3, L2
// - Plain 0..4: legacy rd/wr, exclusive, shared, leave
// - Plain 5..8: evict, upgrade, upgrade SC, writeback
// - Plain 9 commit to L2; 10 read-leave allocate
// - Plain 11/12 prefetch exclusive/shared, no data returned
// - Plain 13 prefetch exclusive purging L1 owners
// - Plain 14 ownership without data, whole line
// - Plain 15 tag fault, receiver frees, dataless reply
// - Regsync 0..3 debug/mapped reads writes; 4..7 reserved
// - Regsync 8..11 barriers type 0..3; 12..15 reserved
// - Global 0..2 icache invalidates; 3 reserved
// - Global 4..6 guest/root TLB invalidates
// - Global 7 barrier; 8..15 reserved
// - Maintenance 0..6 mirror cacheop; 7 only L1I
// - Maintenance 0 indexed flush invalidate
// - Maintenance 1 tag/data read; 2 tag write
// - Maintenance 3 reserved; 4,5,6 address ops
// - Maintenance 7 fetch and pin line
// - Attribute 2 uncached, 7 accel, else coherent shared
// - Type field bits 4:1; 0 request without payload
// - Detail word loads with error type field
// - Type 2 payload, 4..7 intervention, 8..15 responses

//
// Structure
// The error capture holds the detail word and its error type in flops
// as soon as the manager strobes a load. The raw group and command
// fields are shown straight from that hold register one cycle later.
// A second stage turns the held fields into decoded classes, so the
// decoded outputs trail the raw fields by one more cycle. The extra
// stage keeps every output on a flop and costs one cycle of latency.
// Software sees that cycle: a 0x8 read strobed right after the load still returns the previous decode.
//
// Operation code
// The code packs a two-bit class above the four-bit command: class 0
// plain access, 1 register and barrier, 2 global maintenance, 3 cache
// maintenance. All four maintenance groups share class 3 and are told
// apart by the one-hot target. Any reserved group or command, and any
// decode while the enable is clear, gives the all-ones code instead.
//
// Register port
// 0x0 reads the low half of the detail word, 0x4 the error type above
// the high half, 0x8 the decode status with the enable in bit 0, and
// 0xc the error type alone. Writing the held type back to 0xc clears
// the capture. A load in the same cycle wins over that clear, so a
// fresh error is never lost to a late acknowledge.
// Read data stand only in the cycle after the read strobe.
//
// Timing
// Load at edge n: raw fields and valid change at edge n.
// Decoded classes, target and operation change at edge n plus one.
// Both hold until the next load, except that a clear drops valid and the decode enable moves the gated results.
//
// Limitations
// The decoder only names operations. It does not check that a legal
// code is legal for the requester that sent it: a core issuing a
// prefetcher-only command still decodes as that command.
// Clearing the decode enable forces the operation to reserved but
// leaves the attribute and type classes running, since those fields
// mean the same for every group.
// Only the fields shared by every error layout are decoded; the way,
// bank, requester and size fields are left to software.
//

`include "ctad_map.vh"

module ctad_decode #(
    parameter WORD_W = 64                      // Width of the error cause word
) (
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    // Error capture from the manager
    input  wire        i_err_load,             // One-cycle strobe, cause word valid
    input  wire [63:0] i_err_cause,            // Error type plus detail word
    // Register port
    input  wire [3:0]  i_reg_addr,
    input  wire [31:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output wire [31:0] o_reg_rdata,
    // Decoded attributes
    output wire [2:0]  o_group,                // Raw command group
    output wire [3:0]  o_command,              // Raw command
    output wire [5:0]  o_op,                   // Flattened operation code
    output wire        o_op_reserved,          // Group or command reserved
    output wire [3:0]  o_maint_target,         // One-hot L1I,L1D,L3,L2
    output wire [1:0]  o_attr_class,           // Coherency attribute class
    output wire [2:0]  o_type_class,           // Transaction type class
    output wire        o_no_data_reply,        // Receiver answers without data
    output wire        o_valid                 // A detail word is held
);

    // Captured fields
    // The detail word is held whole so software can read it back
    // exactly as the manager presented it.
    reg  [5:0]  etype_q;                       // Error type of the held word
    reg  [57:0] info_q;                        // Held detail word
    reg         valid_q;
    // Decoded results, all registered so outputs come from flops
    reg  [5:0]  op_q,    op_d;
    reg         rsvd_q,  rsvd_d;
    reg  [3:0]  tgt_q,   tgt_d;
    reg  [1:0]  acls_q,  acls_d;
    reg  [2:0]  tcls_q,  tcls_d;
    reg         ndr_q,   ndr_d;
    reg  [31:0] rdata_q, rdata_d;
    reg         dec_en_q;                      // Software decode enable

    wire [2:0] grp = info_q[`CTAD_GRP_HI:`CTAD_GRP_LO];
    wire [3:0] cmd = info_q[`CTAD_CMD_HI:`CTAD_CMD_LO];
    wire [2:0] atr = info_q[`CTAD_ATTR_HI:`CTAD_ATTR_LO];
    wire [3:0] typ = info_q[`CTAD_TYPE_HI:`CTAD_TYPE_LO];

    // Capture the detail word whenever the error type is loaded.
    // A load outranks the software clear below: if both land in one
    // cycle the new error is kept and valid stays set, so software sees
    // a fresh type on its next read instead of losing the event.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            etype_q <= 6'h00;
            info_q  <= 58'h0;
            valid_q <= 1'b0;
        end else if (i_err_load) begin
            etype_q <= i_err_cause[`CTAD_ETYPE_HI:`CTAD_ETYPE_LO];
            info_q  <= i_err_cause[`CTAD_INFO_W-1:0];
            valid_q <= 1'b1;
        end else if (i_reg_wr && i_reg_addr == `CTAD_REG_ETYPE && i_reg_wdata[5:0] == etype_q) begin
            // Writing back the current type clears the capture
            etype_q <= 6'h00;
            valid_q <= 1'b0;
        end
    end

    // Group and command decode into one operation code.
    // The class sits in the top two bits so software can sort by group
    // at a glance; the maintenance groups are told apart by the target.
    // Each command table is spelled out code by code on purpose: a packed
    // range test is shorter, but a miscounted bound would silently map a
    // reserved code onto a real operation.
    always @* begin
        op_d   = `CTAD_OP_RSVD;
        rsvd_d = 1'b0;
        tgt_d  = 4'h0;
        ndr_d  = 1'b0;
        case (grp)
            `CTAD_GRP_PLAIN: begin
                // Plain group: all sixteen codes are defined
                op_d = {2'h0, cmd};
                case (cmd)
                    4'h0:    rsvd_d = 1'b0;
                    4'h1:    rsvd_d = 1'b0;
                    4'h2:    rsvd_d = 1'b0;
                    4'h3:    rsvd_d = 1'b0;
                    4'h4:    rsvd_d = 1'b0;
                    4'h5:    rsvd_d = 1'b0;
                    4'h6:    rsvd_d = 1'b0;
                    4'h7:    rsvd_d = 1'b0;
                    4'h8:    rsvd_d = 1'b0;
                    4'h9:    rsvd_d = 1'b0;
                    4'ha:    rsvd_d = 1'b0;
                    4'hb:    ndr_d  = 1'b1;
                    4'hc:    ndr_d  = 1'b1;
                    4'hd:    rsvd_d = 1'b0;
                    4'he:    rsvd_d = 1'b0;
                    4'hf:    ndr_d  = 1'b1;
                    default: rsvd_d = 1'b0;
                endcase
            end
            `CTAD_GRP_REGSYNC: begin
                // Register access and barriers; the holes are reserved
                op_d = {2'h1, cmd};
                case (cmd)
                    4'h0:    rsvd_d = 1'b0;
                    4'h1:    rsvd_d = 1'b0;
                    4'h2:    rsvd_d = 1'b0;
                    4'h3:    rsvd_d = 1'b0;
                    4'h4:    rsvd_d = 1'b1;
                    4'h5:    rsvd_d = 1'b1;
                    4'h6:    rsvd_d = 1'b1;
                    4'h7:    rsvd_d = 1'b1;
                    4'h8:    rsvd_d = 1'b0;
                    4'h9:    rsvd_d = 1'b0;
                    4'ha:    rsvd_d = 1'b0;
                    4'hb:    rsvd_d = 1'b0;
                    4'hc:    rsvd_d = 1'b1;
                    4'hd:    rsvd_d = 1'b1;
                    4'he:    rsvd_d = 1'b1;
                    4'hf:    rsvd_d = 1'b1;
                    default: rsvd_d = 1'b1;
                endcase
            end
            `CTAD_GRP_GLOBAL: begin
                // Global instruction cache and TLB maintenance
                op_d = {2'h2, cmd};
                case (cmd)
                    4'h0:    rsvd_d = 1'b0;
                    4'h1:    rsvd_d = 1'b0;
                    4'h2:    rsvd_d = 1'b0;
                    4'h3:    rsvd_d = 1'b1;
                    4'h4:    rsvd_d = 1'b0;
                    4'h5:    rsvd_d = 1'b0;
                    4'h6:    rsvd_d = 1'b0;
                    4'h7:    rsvd_d = 1'b0;
                    4'h8:    rsvd_d = 1'b1;
                    4'h9:    rsvd_d = 1'b1;
                    4'ha:    rsvd_d = 1'b1;
                    4'hb:    rsvd_d = 1'b1;
                    4'hc:    rsvd_d = 1'b1;
                    4'hd:    rsvd_d = 1'b1;
                    4'he:    rsvd_d = 1'b1;
                    4'hf:    rsvd_d = 1'b1;
                    default: rsvd_d = 1'b1;
                endcase
            end
            `CTAD_GRP_RSVD: begin
                // No operation lives in this group
                rsvd_d = 1'b1;
            end
            default: begin
                // Cache maintenance groups share one command table
                op_d  = {2'h3, cmd};
                tgt_d = 4'h1 << grp[1:0];
                case (cmd)
                    4'h0:    rsvd_d = 1'b0;
                    4'h1:    rsvd_d = 1'b0;
                    4'h2:    rsvd_d = 1'b0;
                    4'h3:    rsvd_d = 1'b1;
                    4'h4:    rsvd_d = 1'b0;
                    4'h5:    rsvd_d = 1'b0;
                    4'h6:    rsvd_d = 1'b0;
                    4'h7:    rsvd_d = (grp != `CTAD_GRP_L1I);
                    4'h8:    rsvd_d = 1'b1;
                    4'h9:    rsvd_d = 1'b1;
                    4'ha:    rsvd_d = 1'b1;
                    4'hb:    rsvd_d = 1'b1;
                    4'hc:    rsvd_d = 1'b1;
                    4'hd:    rsvd_d = 1'b1;
                    4'he:    rsvd_d = 1'b1;
                    4'hf:    rsvd_d = 1'b1;
                    default: rsvd_d = 1'b1;
                endcase
            end
        endcase
        if (rsvd_d)
            op_d = `CTAD_OP_RSVD;
    end

    // Coherency attribute decode; unlisted codes fold to coherent shared.
    // Every code is listed so a later remap of one value stays one line.
    always @* begin
        case (atr)
            3'h0:                 acls_d = `CTAD_CLS_CRS;
            3'h1:                 acls_d = `CTAD_CLS_CRS;
            `CTAD_ATTR_UNCACHED:  acls_d = `CTAD_CLS_UNCACHED;
            3'h3:                 acls_d = `CTAD_CLS_CRS;
            3'h4:                 acls_d = `CTAD_CLS_CRS;
            `CTAD_ATTR_CRS:       acls_d = `CTAD_CLS_CRS;
            3'h6:                 acls_d = `CTAD_CLS_CRS;
            `CTAD_ATTR_UNC_ACCEL: acls_d = `CTAD_CLS_UNC_ACCEL;
            default:              acls_d = `CTAD_CLS_CRS;
        endcase
    end

    // Transaction type class.
    // Codes 1 and 3 are holes in the request half; they report as
    // reserved rather than being folded into a neighbouring class.
    always @* begin
        case (typ)
            `CTAD_TT_REQ_NODATA: tcls_d = `CTAD_TC_REQ_NODATA;
            4'h1:                tcls_d = `CTAD_TC_RSVD;
            `CTAD_TT_REQ_DATA:   tcls_d = `CTAD_TC_REQ_DATA;
            4'h3:                tcls_d = `CTAD_TC_RSVD;
            4'h4:                tcls_d = `CTAD_TC_INTERVENE;
            4'h5:                tcls_d = `CTAD_TC_INTERVENE;
            4'h6:                tcls_d = `CTAD_TC_INTERVENE;
            4'h7:                tcls_d = `CTAD_TC_INTERVENE;
            4'h8:                tcls_d = `CTAD_TC_RESPONSE;
            4'h9:                tcls_d = `CTAD_TC_RESPONSE;
            4'ha:                tcls_d = `CTAD_TC_RESPONSE;
            4'hb:                tcls_d = `CTAD_TC_RESPONSE;
            4'hc:                tcls_d = `CTAD_TC_RESPONSE;
            4'hd:                tcls_d = `CTAD_TC_RESPONSE;
            4'he:                tcls_d = `CTAD_TC_RESPONSE;
            4'hf:                tcls_d = `CTAD_TC_RESPONSE;
            default:             tcls_d = `CTAD_TC_RSVD;
        endcase
    end

    // Register the decode; disabled decode reports reserved.
    // Only the command-dependent results are gated by the enable: the
    // attribute and type classes carry the same meaning in every group.
    // Registering here keeps every decoded output straight from a flop.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_q   <= `CTAD_OP_RSVD;
            rsvd_q <= 1'b1;
            tgt_q  <= 4'h0;
            acls_q <= `CTAD_CLS_CRS;
            tcls_q <= `CTAD_TC_RSVD;
            ndr_q  <= 1'b0;
        end else begin
            op_q   <= dec_en_q ? op_d   : `CTAD_OP_RSVD;
            rsvd_q <= dec_en_q ? rsvd_d : 1'b1;
            tgt_q  <= dec_en_q ? tgt_d  : 4'h0;
            acls_q <= acls_d;
            tcls_q <= tcls_d;
            ndr_q  <= dec_en_q & ndr_d;
        end
    end

    // Control register: bit 0 enables the command decode.
    // It resets to enabled so a capture decodes without any setup.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            dec_en_q <= 1'b1;
        else if (i_reg_wr && i_reg_addr == `CTAD_REG_DECODE)
            dec_en_q <= i_reg_wdata[0];
    end

    // Read mux; unmapped addresses read zero.
    // Decoded fields are read from the output flops, so the status word
    // always matches what the pins showed in the cycle of the read strobe.
    always @* begin
        case (i_reg_addr)
            `CTAD_REG_CAUSE_LO: rdata_d = info_q[31:0];
            `CTAD_REG_CAUSE_HI: rdata_d = {etype_q, info_q[57:32]};
            `CTAD_REG_DECODE:   rdata_d = {9'h000,     // Spare, reads zero
                                           valid_q,    // Bit 22, word held
                                           ndr_q,      // Bit 21, dataless reply
                                           tcls_q,     // Bits 20:18
                                           acls_q,     // Bits 17:16
                                           tgt_q,      // Bits 15:12
                                           rsvd_q,     // Bit 11
                                           op_q,       // Bits 10:5
                                           4'h0,       // Bits 4:1, spare
                                           dec_en_q};  // Bit 0, decode enable
            `CTAD_REG_ETYPE:    rdata_d = {26'h0, etype_q};
            default:            rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stands one cycle after the strobe only.
    // Returning zero between reads keeps stale words off the bus, at the
    // cost of software having to take the data in exactly that cycle.
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            rdata_q <= 32'h0000_0000;
        else if (i_reg_rd)
            rdata_q <= rdata_d;
        else
            rdata_q <= 32'h0000_0000;
    end

    // Outputs; group and command come straight from the held word,
    // one cycle ahead of the decoded results that follow them.
    // Every one of them is a flop output.
    assign o_reg_rdata    = rdata_q;
    assign o_group        = grp;
    assign o_command      = cmd;
    assign o_op           = op_q;
    assign o_op_reserved  = rsvd_q;
    assign o_maint_target = tgt_q;
    assign o_attr_class   = acls_q;
    assign o_type_class   = tcls_q;
    assign o_no_data_reply = ndr_q;
    assign o_valid        = valid_q;

endmodule // ctad_decode

// ===== verification/ctad_decode_sva.sv
// Assertion checker for the transaction attribute decoder
`timescale 1ns/1ps
module ctad_decode_chk (
    // Clock, reset and capture
    input wire        i_ref_clk,
    input wire        i_rst_n,
    input wire        i_err_load,
    input wire [63:0] i_err_cause,
    // Register port
    input wire [3:0]  i_reg_addr,
    input wire        i_reg_rd,
    input wire [31:0] o_reg_rdata,
    // Decoded outputs
    input wire [2:0]  o_group,
    input wire [3:0]  o_command,
    input wire [5:0]  o_op,
    input wire        o_op_reserved,
    input wire [3:0]  o_maint_target,
    input wire [1:0]  o_attr_class,
    input wire [2:0]  o_type_class,
    input wire        o_no_data_reply,
    input wire        o_valid
);
    // Cause word two cycles back, the one the decoded outputs describe
    reg  [63:0] c1_q;
    reg  [63:0] c2_q;
    wire [2:0]  g = c2_q[13:11];
    wire [3:0]  c = c2_q[17:14];
    wire [2:0]  a = c2_q[10:8];
    wire [3:0]  t = c2_q[4:1];

    // Delay line only, no reset needed since it is read after a load
    always @(posedge i_ref_clk) begin
        c1_q <= i_err_cause;
        c2_q <= c1_q;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // A load whose decode has settled
    sequence ld2;
        i_err_load ##2 1'b1;
    endsequence
    // A load followed at once by a read of the low cause word
    sequence lo_rd;
        i_err_load ##1 (i_reg_rd && i_reg_addr == 4'h0 && !i_err_load);
    endsequence

    grp_capture_a: assert property (i_err_load |=>
        o_group == $past(i_err_cause[13:11]) && o_command == $past(i_err_cause[17:14]) && o_valid)
        else $error("group or command not captured");
    rsvd_group_a: assert property (ld2 |-> g != 3'h3 || (o_op_reserved && o_op == 6'h3f))
        else $error("reserved group decoded as an operation");
    attr_class_a: assert property (ld2 |-> o_attr_class == (a == 3'h2 ? 2'h1 : a == 3'h7 ? 2'h2 : 2'h0))
        else $error("attribute class wrong");
    type_class_a: assert property (ld2 |->
        o_type_class == (t == 4'h0 ? 3'h0 : t == 4'h2 ? 3'h1 : t[3] ? 3'h3 : t[2] ? 3'h2 : 3'h4))
        else $error("type class wrong");
    maint_target_a: assert property (ld2 ##0 (g[2] && !o_op_reserved) |-> o_maint_target == (4'h1 << g[1:0]))
        else $error("maintenance target wrong");
    no_data_a: assert property (ld2 |-> o_no_data_reply == (g == 3'h0 && (c == 4'hb || c == 4'hc || c == 4'hf)))
        else $error("no-data reply flag wrong");
    regsync_rsvd_a: assert property (ld2 ##0 (g == 3'h1) |-> o_op_reserved == c[2])
        else $error("register group reserved flag wrong");
    cause_read_a: assert property (lo_rd |=> o_reg_rdata == c2_q[31:0])
        else $error("low cause word read back wrong");
endmodule // ctad_decode_chk

bind ctad_decode ctad_decode_chk chk_u (.i_ref_clk, .i_rst_n, .i_err_load, .i_err_cause, .i_reg_addr, .i_reg_rd,
    .o_reg_rdata, .o_group, .o_command, .o_op, .o_op_reserved, .o_maint_target, .o_attr_class, .o_type_class,
    .o_no_data_reply, .o_valid);

// ===== verification/testbench.sv
// Self-checking bench for the transaction attribute decoder
`timescale 1ns/1ps
module testbench;
    logic        i_ref_clk = 0, i_rst_n = 0, i_err_load = 0, i_reg_wr = 0, i_reg_rd = 0;
    logic [63:0] i_err_cause = 0;
    logic [3:0]  i_reg_addr = 0;
    logic [31:0] i_reg_wdata = 0;
    wire  [31:0] o_reg_rdata;
    wire  [5:0]  o_op;
    wire  [3:0]  o_command, o_maint_target;
    wire  [2:0]  o_group, o_type_class;
    wire  [1:0]  o_attr_class;
    wire         o_op_reserved, o_no_data_reply, o_valid;
    int          failures = 0, num_checks = 0, i;
    logic [2:0]  g, tc;
    logic [3:0]  c, tg;
    logic [1:0]  ac;
    logic [5:0]  op;
    logic        r, nd;

    ctad_decode dut_u (.i_ref_clk, .i_rst_n, .i_err_load, .i_err_cause, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
        .i_reg_rd, .o_reg_rdata, .o_group, .o_command, .o_op, .o_op_reserved, .o_maint_target,
        .o_attr_class, .o_type_class, .o_no_data_reply, .o_valid);

    // 20 MHz clock
    always #25 i_ref_clk = ~i_ref_clk;

    task chk(input string n, input [31:0] e, input [31:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // Load a cause word, read the low word back in the very next cycle
    task ld(input [63:0] w);
        @(posedge i_ref_clk);
        i_err_load <= 1; i_err_cause <= w;
        @(posedge i_ref_clk);
        i_err_load <= 0; i_reg_rd <= 1; i_reg_addr <= 4'h0;
        @(posedge i_ref_clk);
        i_reg_rd <= 0;
        #1 chk("cause_lo", w[31:0], o_reg_rdata);
    endtask

    task rd(input [3:0] a, input [31:0] e, input string n);
        @(posedge i_ref_clk);
        i_reg_rd <= 1; i_reg_addr <= a;
        @(posedge i_ref_clk);
        i_reg_rd <= 0;
        #1 chk(n, e, o_reg_rdata);
    endtask

    task wr(input [3:0] a, input [31:0] d);
        @(posedge i_ref_clk);
        i_reg_wr <= 1; i_reg_addr <= a; i_reg_wdata <= d;
        @(posedge i_ref_clk);
        i_reg_wr <= 0;
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #(50 * 20000);
        failures++;
        stop_test;
    end

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1;
        // Every group and command; attribute and type fields ride along on the command bits
        for (i = 0; i < 128; i++) begin
            g = i[6:4];
            c = i[3:0];
            r = g == 3 || (g == 1 && c[2]) || (g == 2 && (c == 3 || c[3])) || (g[2] && (c == 3 || c[3] || (c == 7 && g != 4)));
            op = r ? 6'h3f : {(g[2] ? 2'b11 : g[1:0]), c};
            ac = c[2:0] == 2 ? 2'h1 : c[2:0] == 7 ? 2'h2 : 2'h0;
            tc = c == 0 ? 3'h0 : c == 2 ? 3'h1 : c[3] ? 3'h3 : c[2] ? 3'h2 : 3'h4;
            tg = (g[2] && !r) ? 4'h1 << g[1:0] : 4'h0;
            nd = g == 0 && (c == 11 || c == 12 || c == 15);
            ld({6'h01, 40'h0, c, g, c[2:0], 3'h0, c, 1'b0});
            chk("group", g, o_group);
            chk("command", c, o_command);
            chk("op", op, o_op);
            chk("reserved", r, o_op_reserved);
            chk("no_data", nd, o_no_data_reply);
            chk("attr", ac, o_attr_class);
            chk("type", tc, o_type_class);
            if (!r) chk("target", tg, o_maint_target);
            if (!r) rd(4'h8, {9'h0, 1'b1, nd, tc, ac, tg, 1'b0, op, 4'h0, 1'b1}, "decode");
        end
        $display("test decode_sweep done");
        rd(4'h4, 32'h0400_0000, "cause_hi");
        rd(4'hc, 32'h0000_0001, "etype");
        rd(4'h2, 32'h0000_0000, "unmapped");
        // Decode disabled hides the operation
        wr(4'h8, 32'h0000_0000);
        ld(64'h0400_0000_0000_0000);
        chk("op_off", 6'h3f, o_op);
        wr(4'h8, 32'h0000_0001);
        // Writing the held type back clears it
        wr(4'hc, 32'h0000_0001);
        #1 chk("valid", 1'b0, o_valid);
        rd(4'hc, 32'h0000_0000, "etype_clr");
        $display("test registers done");
        stop_test;
    end
endmodule // testbench
